// [hw/timer_counter_pwm_unit_pkg.sv]
// Purpose: shared constants and types for the timer/counter/pwm array
// Assumes: 16-bit counters, plain register port, 20 MHz sys_clk
// Notes:   eight channels, register index = channel*8 + register
package timer_pwm_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int          NUM_UNITS   = 8;
   localparam int          CNT_W       = 16;
   localparam int          ADDR_W      = 6;
   localparam int          DATA_W      = 32;

   // ****************************************
   // register offsets within one channel
   // ****************************************
   localparam logic [2:0]  REG_CTRL    = 3'h0;  // control bits
   localparam logic [2:0]  REG_PERIOD  = 3'h1;  // period value
   localparam logic [2:0]  REG_CMP     = 3'h2;  // duty compare
   localparam logic [2:0]  REG_DEAD    = 3'h3;  // dead-band cycles
   localparam logic [2:0]  REG_COUNT   = 3'h4;  // live count, writable
   localparam logic [2:0]  REG_CAPT    = 3'h5;  // captured count
   localparam logic [2:0]  REG_STATUS  = 3'h6;  // running, kill seen

   // ****************************************
   // control field positions
   // ****************************************
   localparam int          CTRL_EN     = 0;   // counter enable
   localparam int          CTRL_ONESHOT= 1;   // 1: halt on period match
   localparam int          CTRL_QUAD   = 2;   // 1: quadrature drives count
   localparam int          CTRL_KILLTRUE = 3; // true-output level in kill
   localparam int          CTRL_KILLCOMP = 4; // comp-output level in kill
   localparam int          CTRL_W      = 5;

   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   localparam logic [CNT_W-1:0]  PERIOD_RESET = 16'hFFFF;
   localparam logic [CNT_W-1:0]  ZERO16   = 16'h0000;

   // ****************************************
   // carriers
   // ****************************************
   // first field is the top bit, so the list runs from bit 4 down
   typedef struct packed {
      logic              killComp;
      logic              killTrue;
      logic              quadMode;
      logic              oneShot;
      logic              enable;
   } ctrl_t;

   typedef struct packed {
      logic              capture;   // synchronised capture level
      logic              phaseA;    // synchronised encoder phase a
      logic              phaseB;    // synchronised encoder phase b
      logic              kill;      // synchronised shutdown level
   } events_t;

   typedef struct packed {
      logic              pwmTrue;
      logic              pwmComp;
   } pwm_out_t;

endpackage

// [hw/timer_counter_pwm_unit_channel.sv]
// Purpose: one 16-bit timer/counter/pwm channel
// Assumes: events already synchronised to sys_clk
// Notes:   outputs except running are raw flops; top registers pwm again
`timescale 1ns/1ps
module timer_pwm_channel
   import timer_pwm_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             clkEn,
   input  wire ctrl_t            ctrl,
   input  wire logic [CNT_W-1:0] period,
   input  wire logic [CNT_W-1:0] compare,
   input  wire logic [CNT_W-1:0] deadCycles,
   input  wire logic             countWr,
   input  wire logic [CNT_W-1:0] countWrData,
   input  wire events_t          ev,
   output logic [CNT_W-1:0]      count,
   output logic [CNT_W-1:0]      capture,
   output logic                  running,
   output pwm_out_t              pwm
);

   // ****************************************
   // edge history of synchronised inputs, plus counter and output state
   // ****************************************
   logic                  captPrev;   // last capture level
   logic                  aPrev;      // last phase a
   logic                  bPrev;      // last phase b
   logic                  halted;     // one-shot stop reached
   logic                  rawPwm;     // compare result
   logic                  rawPrev;    // compare result last cycle
   logic [CNT_W-1:0]      deadCnt;    // dead-band remaining

   // quadrature step decode from old and new phase pairs
   function automatic logic [1:0] quadStep(input logic a0, input logic b0,
                                           input logic a1, input logic b1);
      // returns {valid, up}
      logic e;
      e = (a0 ^ a1) ^ (b0 ^ b1);
      // up when the new a differs from the old b
      quadStep = {e, (a1 ^ b0)};
   endfunction

   logic [1:0]            step;
   assign step    = quadStep(aPrev, bPrev, ev.phaseA, ev.phaseB);
   assign running = ctrl.enable & ~halted;

   // history flops
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         captPrev <= 1'b0;
         aPrev    <= 1'b0;
         bPrev    <= 1'b0;
      end else if (clkEn) begin
         captPrev <= ev.capture;
         aPrev    <= ev.phaseA;
         bPrev    <= ev.phaseB;
      end
   end

   // counter: timer mode or quadrature mode
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count  <= ZERO16;
         halted <= 1'b0;
      end else if (clkEn) begin
         if (countWr) begin
            // software load also re-arms a one-shot
            count  <= countWrData;
            halted <= 1'b0;
         end else if (!ctrl.enable) begin
            halted <= 1'b0;
         end else if (ctrl.quadMode) begin
            if (step[1]) begin
               // a leading b counts up, b leading a counts down
               count <= step[0] ? count + 16'h0001
                                : count - 16'h0001;
            end
         end else if (!halted) begin
            if (count == period) begin
               // match: stop or auto-reload
               if (ctrl.oneShot) begin
                  halted <= 1'b1;
               end else begin
                  count <= ZERO16;
               end
            end else begin
               count <= count + 16'h0001;
            end
         end
      end
   end

   // capture on rising edge of capture input
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         capture <= ZERO16;
      end else if (clkEn && ev.capture && !captPrev) begin
         capture <= count;
      end
   end

   // compare sets duty: high while count below compare
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rawPwm  <= 1'b0;
         rawPrev <= 1'b0;
      end else if (clkEn) begin
         rawPwm  <= running & (count < compare);
         rawPrev <= rawPwm;
      end
   end

   // dead-band: both low for the transition cycle and deadCycles more after it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         deadCnt <= ZERO16;
      end else if (clkEn) begin
         if (rawPwm != rawPrev) begin
            deadCnt <= deadCycles;
         end else if (deadCnt != ZERO16) begin
            deadCnt <= deadCnt - 16'h0001;
         end
      end
   end

   // output stage; kill overrides at once, no software in loop
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pwm <= '0;
      end else if (ev.kill) begin
         pwm.pwmTrue <= ctrl.killTrue;
         pwm.pwmComp <= ctrl.killComp;
      end else if (clkEn) begin
         if (rawPwm != rawPrev || deadCnt != ZERO16) begin
            pwm <= '0;
         end else begin
            pwm.pwmTrue <= rawPwm;
            pwm.pwmComp <= ~rawPwm;
         end
      end
   end

endmodule

// [hw/timer_counter_pwm_unit.sv]
// Purpose: eight timer/counter/pwm channels behind a register port
// Assumes: pins asynchronous to sys_clk; 20 MHz clock
// Notes:   kill acts two sync stages after the pin, independent of clkEn
//          register index is unit*8 + register; unit 7 fills the map
//          a write to an unmapped register is dropped, a read gives zero
//          encoder phases must hold each state for two clocks or more
//          outputs lag the channel by one flop so pins never glitch
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module timer_counter_pwm_unit
   import timer_pwm_pkg::*;
#(
   parameter int UNITS = NUM_UNITS
)
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              clkEn,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWrData,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic [DATA_W-1:0]      regRdData,
   input  wire logic [UNITS-1:0]  captureIn,
   input  wire logic [UNITS-1:0]  phaseAIn,
   input  wire logic [UNITS-1:0]  phaseBIn,
   input  wire logic [UNITS-1:0]  killIn,
   output logic [UNITS-1:0]       pwmTrueOut,
   output logic [UNITS-1:0]       pwmCompOut
);

   // ****************************************
   // address decode
   // ****************************************
   // low three bits pick the register inside a unit, the top three
   // bits pick the unit; the write path and the read path both need
   // them, so they live in functions and the two decodes can never
   // drift apart
   // register within a unit
   function automatic logic [2:0] regSel(input logic [ADDR_W-1:0] a);
      regSel = a[2:0];
   endfunction

   // unit number
   function automatic logic [2:0] unitSel(input logic [ADDR_W-1:0] a);
      unitSel = a[5:3];
   endfunction

   // ****************************************
   // per-unit state and synchronisers
   // ****************************************
   // configuration sits here rather than in the channel so the read
   // mux can reach every unit without extra ports; the channel only
   // holds the live counter, the capture and the output state
   // the arrays are small, one word per unit, so plain flops are used
   // and no memory macro is needed
   ctrl_t            ctrlReg   [UNITS];   // control per unit
   logic [CNT_W-1:0] periodReg [UNITS];   // period per unit
   logic [CNT_W-1:0] cmpReg    [UNITS];   // compare per unit
   logic [CNT_W-1:0] deadReg   [UNITS];   // dead-band per unit
   logic [CNT_W-1:0] countW    [UNITS];   // live count
   logic [CNT_W-1:0] captW     [UNITS];   // capture value
   logic [UNITS-1:0] runW;                // running flags
   logic [UNITS-1:0] killSeenReg;         // sticky kill seen
   pwm_out_t         pwmW      [UNITS];   // channel outputs
   logic [3:0]       syncA     [UNITS];   // first sync stage
   logic [3:0]       syncB     [UNITS];   // second sync stage

   // ****************************************
   // per-unit logic, one copy for each channel
   // ****************************************
   genvar u;
   generate
      for (u = 0; u < UNITS; u++) begin : g_unit
         // nets local to one unit
         events_t ev;
         logic    hit;                    // this unit addressed
         logic    cntWr;

         // this unit's share of the bus and its synchronised events
         assign hit   = (unitSel(regAddr) == 3'(u));
         assign cntWr = regWr & hit & (regSel(regAddr) == REG_COUNT);
         assign ev    = syncB[u];

         // two-flop synchronisers; only stage b is read
         // the pins run free against sys_clk, so stage a may go
         // metastable and nothing but stage b may look at it; the
         // reset value matches the idle pin level, so no false
         // capture or encoder edge follows reset
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               syncA[u] <= 4'h0;
               syncB[u] <= 4'h0;
            end else begin
               // kill must not freeze with clkEn
               syncA[u] <= {captureIn[u], phaseAIn[u], phaseBIn[u],
                            killIn[u]};
               syncB[u] <= syncA[u];
            end
         end

         // software-written configuration
         // a write with clkEn low is dropped like any other frozen
         // state; count and status writes are handled further down,
         // so those codes fall through the default branch here
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               ctrlReg[u]   <= CTRL_RESET;
               periodReg[u] <= PERIOD_RESET;
               cmpReg[u]    <= ZERO16;
               deadReg[u]   <= ZERO16;
            end else if (clkEn && regWr && hit) begin
               unique case (regSel(regAddr))
                  REG_CTRL:   ctrlReg[u]   <= regWrData[CTRL_W-1:0];
                  REG_PERIOD: periodReg[u] <= regWrData[CNT_W-1:0];
                  REG_CMP:    cmpReg[u]    <= regWrData[CNT_W-1:0];
                  REG_DEAD:   deadReg[u]   <= regWrData[CNT_W-1:0];
                  default:    ;
               endcase
            end
         end

         // sticky kill flag; a new kill wins over a clear
         // set from the synchronised level, not gated by clkEn, so a
         // fault is never lost while the block is frozen
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               killSeenReg[u] <= 1'b0;
            end else if (ev.kill) begin
               killSeenReg[u] <= 1'b1;
            end else if (clkEn && regWr && hit &&
                         regSel(regAddr) == REG_STATUS) begin
               killSeenReg[u] <= 1'b0;
            end
         end

         // one independent channel per unit
         // the count load is gated here so a frozen block ignores it
         // just as it ignores configuration writes
         timer_pwm_channel i_chan (
            .sys_clk     (sys_clk),
            .rst         (rst),
            .clkEn       (clkEn),
            .ctrl        (ctrlReg[u]),
            .period      (periodReg[u]),
            .compare     (cmpReg[u]),
            .deadCycles  (deadReg[u]),
            .countWr     (clkEn & cntWr),
            .countWrData (regWrData[CNT_W-1:0]),
            .ev          (ev),
            .count       (countW[u]),
            .capture     (captW[u]),
            .running     (runW[u]),
            .pwm         (pwmW[u])
         );

         // outputs straight from flops
         // not gated by clkEn: a kill must reach the pins even while
         // the rest of the block is frozen; the price is one cycle of
         // extra delay from channel to pin
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               pwmTrueOut[u] <= 1'b0;
               pwmCompOut[u] <= 1'b0;
            end else begin
               pwmTrueOut[u] <= pwmW[u].pwmTrue;
               pwmCompOut[u] <= pwmW[u].pwmComp;
            end
         end
      end
   endgenerate

   // ****************************************
   // read port: data in the cycle after the strobe
   // ****************************************
   // the mux is plain logic; only the flop behind it is seen at the
   // port, which keeps the answer to one fixed cycle
   logic [DATA_W-1:0] rdMux;   // combinational read select
   logic [2:0]        rdUnit;  // unit field of the read address

   // select the addressed register; absent units read zero
   always_comb begin
      rdUnit = unitSel(regAddr);
      rdMux  = '0;
      // guard keeps a smaller build from indexing past its arrays
      if (32'(rdUnit) < UNITS) begin
         unique case (regSel(regAddr))
            REG_CTRL:   rdMux = {27'h0, ctrlReg[rdUnit]};
            REG_PERIOD: rdMux = {16'h0000, periodReg[rdUnit]};
            REG_CMP:    rdMux = {16'h0000, cmpReg[rdUnit]};
            REG_DEAD:   rdMux = {16'h0000, deadReg[rdUnit]};
            REG_COUNT:  rdMux = {16'h0000, countW[rdUnit]};
            REG_CAPT:   rdMux = {16'h0000, captW[rdUnit]};
            REG_STATUS: rdMux = {30'h0, killSeenReg[rdUnit], runW[rdUnit]};
            default:    rdMux = '0;   // unmapped reads zero
         endcase
      end
   end

   // read data register; zero outside the answer cycle
   // returning to zero keeps a stale value from being taken for a
   // fresh answer by a master that samples one cycle late
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdData <= '0;
      end else if (clkEn && regRd) begin
         regRdData <= rdMux;
      end else begin
         regRdData <= '0;
      end
   end

endmodule

// [tb/quad_encoder_model.sv]
// Purpose: encoder partner, steps two phases in gray order
// Assumes: at most one step request per clock
// Notes:   phases only move on request, so the count stays predictable
`timescale 1ns/1ps
module quad_encoder_model (
   input  wire logic sys_clk,
   input  wire logic stepUp,
   input  wire logic stepDn,
   output logic      phaseA,
   output logic      phaseB
);
   logic [1:0] pos = 2'h0;  // gray position, 00 10 11 01
   // one position per request; a leads b when going up
   always @(posedge sys_clk) begin
      if (stepUp) begin
         pos <= pos + 2'h1;
      end else if (stepDn) begin
         pos <= pos - 2'h1;
      end
   end
   assign phaseA = pos[1] ^ pos[0];
   assign phaseB = pos[1];
endmodule

// [tb/timer_counter_pwm_unit_properties.sv]
// Purpose: port-level properties of the timer array
// Assumes: one clock, asynchronous active-high reset
// Notes:   unit 0 outputs watched; kill levels are not visible here
`timescale 1ns/1ps
module timer_pwm_properties
   import timer_pwm_pkg::*;
#(
   parameter int UNITS = NUM_UNITS
)
(
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire logic              clkEn,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic              regRd,
   input wire logic [DATA_W-1:0] regRdData,
   input wire logic [UNITS-1:0]  killIn,
   input wire logic [UNITS-1:0]  pwmTrueOut,
   input wire logic [UNITS-1:0]  pwmCompOut
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // read data must sit at zero unless a read was taken
   property p_rdIdle;
      !$past(regRd) |-> regRdData == '0;
   endproperty
   a_rdIdle: assert property (p_rdIdle)
      else $error("read data not idle");
   property p_unmapped;
      regRd && clkEn && regAddr[2:0] == 3'h7 |=> regRdData == '0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_gated;
      regRd && !clkEn |=> regRdData == '0;
   endproperty
   a_gated: assert property (p_gated)
      else $error("gated read answered");
   property p_wide16;
      regRd && clkEn && regAddr[2:0] inside {[3'h1:3'h5]}
         |=> regRdData[31:16] == 16'h0000;
   endproperty
   a_wide16: assert property (p_wide16)
      else $error("upper read bits set");
   // a held kill freezes both outputs
   property p_killHold;
      killIn[0] [*6] |-> $stable(pwmTrueOut[0]) && $stable(pwmCompOut[0]);
   endproperty
   a_killHold: assert property (p_killHold)
      else $error("outputs moved under kill");
   property p_noOverlap;
      (!killIn[0]) [*6] |-> !(pwmTrueOut[0] && pwmCompOut[0]);
   endproperty
   a_noOverlap: assert property (p_noOverlap)
      else $error("both outputs high");
   // a rising output needs its partner low the cycle before
   property p_deadTrue;
      (!killIn[0]) [*6] ##0 $rose(pwmTrueOut[0]) |-> !$past(pwmCompOut[0]);
   endproperty
   a_deadTrue: assert property (p_deadTrue)
      else $error("true rose without gap");
   property p_deadComp;
      (!killIn[0]) [*6] ##0 $rose(pwmCompOut[0]) |-> !$past(pwmTrueOut[0]);
   endproperty
   a_deadComp: assert property (p_deadComp)
      else $error("comp rose without gap");
endmodule
bind timer_counter_pwm_unit timer_pwm_properties #(.UNITS(UNITS))
   timer_pwm_properties_inst (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
   .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData),
   .killIn(killIn), .pwmTrueOut(pwmTrueOut), .pwmCompOut(pwmCompOut));

// [tb/tb_top.sv]
// Purpose: self-checking bench for the eight-channel timer array
// Assumes: 50 ns clock, seed 68, kill levels set while kill is low
// Notes:   duty measured over whole periods, so phase does not matter
`timescale 1ns/1ps
module tb_top;
   import timer_pwm_pkg::*;
   logic              sys_clk, rst, clkEn, regWr, regRd;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWrData, regRdData;
   logic [7:0]        captureIn, phaseAIn, phaseBIn, killIn;
   logic [7:0]        pwmTrueOut, pwmCompOut, stepUp, stepDn;
   logic [15:0]       p, v, c, d;
   int                failures, check_count, rnd, u, k, n, nT, nC;
   timer_counter_pwm_unit #(.UNITS(8)) timer_counter_pwm_unit_inst (
      .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .captureIn(captureIn),
      .phaseAIn(phaseAIn), .phaseBIn(phaseBIn), .killIn(killIn),
      .pwmTrueOut(pwmTrueOut), .pwmCompOut(pwmCompOut));
   // one encoder per unit so every decoder sees traffic
   for (genvar g = 0; g < 8; g++) begin : enc
      quad_encoder_model quad_encoder_model_inst (.sys_clk(sys_clk),
         .stepUp(stepUp[g]), .stepDn(stepDn[g]),
         .phaseA(phaseAIn[g]), .phaseB(phaseBIn[g]));
   end
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // ****************************************
   // bus tasks and expectations
   // ****************************************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input int un, input logic [2:0] r, input logic [15:0] dat);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= {3'(un), r};
      regWrData <= {16'h0000, dat};
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   // data is looked at only in the one cycle it stands
   task rd(input int un, input logic [2:0] r, input logic [15:0] e);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= {3'(un), r};
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(negedge sys_clk);
      check(regRdData, {16'h0000, e});
      // hand back at a rising edge so later stimulus stays on it
      @(posedge sys_clk);
   endtask
   task step(input int un, input bit up);
      @(posedge sys_clk);
      stepUp[un] <= up;
      stepDn[un] <= !up;
      @(posedge sys_clk);
      stepUp[un] <= 1'b0;
      stepDn[un] <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   // count after kk enabled edges, halting or wrapping
   function automatic logic [15:0] expCount(logic [15:0] vv, int kk,
      logic [15:0] pp, bit one);
      int s;
      s = vv + kk;
      if (one) return (s > pp) ? pp : 16'(s);
      return 16'(s % (pp + 1));
   endfunction
   task report_and_stop;
      $display("checks=%0d mismatches=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard
   initial begin
      #5000000;
      failures++;
      report_and_stop;
   end
   initial begin
      {rst, clkEn, regWr, regRd} = 4'hC;
      {regAddr, regWrData, captureIn, killIn, stepUp, stepDn} = '0;
      failures = 0;
      check_count = 0;
      rnd = $urandom(68);
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      for (u = 0; u < 8; u++) begin
         rd(u, REG_CTRL, 16'h0000);
         rd(u, REG_PERIOD, PERIOD_RESET);
         rd(u, REG_CMP, 16'h0000);
         rd(u, REG_DEAD, 16'h0000);
         rd(u, REG_CAPT, 16'h0000);
         rd(u, 3'h7, 16'h0000);
      end
      $display("test reset values done");
      // a write or read with the clock enable low is ignored
      v = 16'($urandom);
      wr(0, REG_PERIOD, v);
      clkEn <= 1'b0;
      wr(0, REG_PERIOD, ~v);
      rd(0, REG_PERIOD, 16'h0000);
      clkEn <= 1'b1;
      rd(0, REG_PERIOD, v);
      $display("test register access done");
      for (n = 0; n < 6; n++) begin
         u = $urandom % 8;
         p = 16'($urandom % 40 + 10);
         v = 16'($urandom) % p;
         k = (n == 1) ? p - v - 1 : $urandom % 90;
         wr(u, REG_PERIOD, p);
         wr(u, REG_COUNT, v);
         wr(u, REG_CTRL, (n > 2) ? 16'h0003 : 16'h0001);
         repeat (k) @(posedge sys_clk);
         wr(u, REG_CTRL, 16'h0000);
         rd(u, REG_COUNT, expCount(v, k + 2, p, n > 2));
      end
      $display("test period done");
      for (u = 0; u < 8; u++) begin
         v = 16'($urandom);
         wr(u, REG_COUNT, v);
         captureIn[u] <= 1'b1;
         repeat (5) @(posedge sys_clk);
         captureIn[u] <= 1'b0;
         rd(u, REG_CAPT, v);
         n = $urandom % 20;
         k = $urandom % 20;
         wr(u, REG_PERIOD, 16'hFFFF);
         wr(u, REG_COUNT, 16'h8000);
         wr(u, REG_CTRL, 16'h0005);
         repeat (n) step(u, 1'b1);
         rd(u, REG_COUNT, 16'(32768 + n));
         repeat (k) step(u, 1'b0);
         rd(u, REG_COUNT, 16'(32768 + n - k));
         wr(u, REG_CTRL, 16'h0000);
      end
      $display("test capture and encoder done");
      for (u = 0; u < 8; u++) begin
         p = 16'h0013;
         d = (u == 0) ? 16'h0000 : 16'($urandom % 3);
         c = 16'($urandom % 8) + d + 16'h0002;
         wr(u, REG_PERIOD, p);
         wr(u, REG_CMP, c);
         wr(u, REG_DEAD, d);
         // start at zero: a count above the period runs on to the wrap
         wr(u, REG_COUNT, 16'h0000);
         wr(u, REG_CTRL, 16'h0001);
         repeat (30) @(posedge sys_clk);
         nT = 0;
         nC = 0;
         repeat (60) begin
            @(negedge sys_clk);
            nT += pwmTrueOut[u];
            nC += pwmCompOut[u];
         end
         check(nT, 3 * (c - d - 1));
         check(nC, 3 * (p - c - d));
         for (k = 0; k < 4; k++) begin
            wr(u, REG_CTRL, 16'(k * 8 + 1));
            killIn[u] <= 1'b1;
            repeat (4) @(posedge sys_clk);
            @(negedge sys_clk);
            check({pwmCompOut[u], pwmTrueOut[u]}, k);
            rd(u, REG_STATUS, 16'h0003);
            killIn[u] <= 1'b0;
            repeat (4) @(posedge sys_clk);
            wr(u, REG_STATUS, 16'h0000);
            rd(u, REG_STATUS, 16'h0001);
         end
         wr(u, REG_CTRL, 16'h0000);
      end
      $display("test pwm and kill done");
      report_and_stop;
   end
endmodule
